// ===== rtl/rsc_reset_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module rsc_reset_ctrl
   import rsc_pkg::*;
(
   // Clock and reset.
   input  wire logic              i_clk,
   input  wire logic              i_rst,
   // Options and mode.
   input  wire logic              i_xtal_option,
   input  wire logic              i_watchdog_reset_select_option,
   input  wire logic              i_brownout_always_on_option,
   input  wire logic              i_stop_mode,
   input  wire logic              i_pin_reset_enable,
   // Reset sources and cause-flag read.
   input  wire logic              i_supply_ok,
   input  wire logic              i_supply_brownout_reset,
   input  wire logic              i_watchdog_timeout,
   input  wire logic              i_debugger_control_register_bit0,
   input  wire logic              i_debug_pin_error,
   input  wire logic [GPIO_W-1:0] i_gpio_in,
   input  wire logic [GPIO_W-1:0] i_gpio_recovery_en,
   input  wire logic              i_cause_read,
   // Shared reset pin.
   input  wire logic              i_shared_reset_pin,
   output logic                   o_shared_reset_pin_out,
   output logic                   o_shared_reset_pin_oe,
   // Outputs.
   output logic                   o_cpu_reset,
   output logic                   o_periph_reset,
   output logic                   o_ctrl_reg_load,
   output logic                   o_wdt_oscillator_control_register_reset,
   output logic                   o_debugger_bit_clear,
   output logic                   o_gpio_reset,
   output logic                   o_sysclk_sel_ipo,
   output logic                   o_brownout_enable,
   output logic                   o_watchdog_irq,
   output logic [15:0]            o_vector_addr,
   output logic [7:0]             o_reset_cause_status
);
   // ==========================================================
   // Synchronisers for asynchronous inputs.
   logic [2:0] pin_sync_reg;
   logic [2:0] sup_sync_reg;
   logic [2:0] bo_sync_reg;
   logic [2:0] dbg_sync_reg;
   logic [GPIO_W-1:0] gp_s1_reg;
   logic [GPIO_W-1:0] gp_s2_reg;
   logic [GPIO_W-1:0] gp_s3_reg;
   logic pin_low;
   logic sup_ok;
   logic bo;
   logic dbg_err;
   logic [GPIO_W-1:0] gpio_chg;
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         pin_sync_reg <= 3'h7;
         sup_sync_reg <= 3'h0;
         bo_sync_reg  <= 3'h0;
         dbg_sync_reg <= 3'h0;
         gp_s1_reg    <= '0;
         gp_s2_reg    <= '0;
         gp_s3_reg    <= '0;
      end
      else
      begin
         pin_sync_reg <= {pin_sync_reg[1:0], i_shared_reset_pin};
         sup_sync_reg <= {sup_sync_reg[1:0], i_supply_ok};
         bo_sync_reg  <= {bo_sync_reg[1:0], i_supply_brownout_reset};
         dbg_sync_reg <= {dbg_sync_reg[1:0], i_debug_pin_error};
         gp_s1_reg    <= i_gpio_in;
         gp_s2_reg    <= gp_s1_reg;
         gp_s3_reg    <= gp_s2_reg;
      end
   end
   assign pin_low  = ~pin_sync_reg[1] & ~pin_sync_reg[2];
   assign sup_ok   = sup_sync_reg[1] & sup_sync_reg[2];
   assign bo       = bo_sync_reg[1] & bo_sync_reg[2];
   assign dbg_err  = dbg_sync_reg[1] & dbg_sync_reg[2];
   assign gpio_chg = (gp_s2_reg ^ gp_s3_reg) & i_gpio_recovery_en;

   // ==========================================================
   // Pin low-time filter.
   localparam int unsigned PIN_LOW_CLKS = PIN_MIN_CLKS - 2;
   logic [2:0] pin_cnt_reg;
   logic       pin_req;
   always_ff @(posedge i_clk)
   begin
      if (i_rst | ~pin_low)
         pin_cnt_reg <= 3'h0;
      else if (pin_cnt_reg != 3'(PIN_LOW_CLKS))
         pin_cnt_reg <= pin_cnt_reg + 3'h1;
   end
   // Three-stage sampling at 100 ns also rejects 12 ns glitches in stop.
   assign pin_req = i_pin_reset_enable & pin_low &
                    (i_stop_mode | (pin_cnt_reg == 3'(PIN_LOW_CLKS)));

   // ==========================================================
   // Request decode.
   logic sup_bad;
   logic wdt_sys;
   logic dbg_sys;
   logic sys_req;
   logic smr_req;
   logic bo_active;
   assign bo_active = ~i_stop_mode | i_brownout_always_on_option;
   assign sup_bad   = ~sup_ok | (bo & bo_active);
   assign wdt_sys   = i_watchdog_timeout & i_watchdog_reset_select_option
                      & ~i_stop_mode;
   assign dbg_sys   = (i_debugger_control_register_bit0 & ~i_stop_mode)
                      | (dbg_err & i_stop_mode);
   assign sys_req   = sup_bad | wdt_sys | dbg_sys | pin_req;
   assign smr_req   = i_stop_mode
                      & (i_watchdog_timeout | (|gpio_chg));

   // ==========================================================
   // Sequencer.
   localparam logic [CNT_W-1:0] HOLD_S = CNT_W'(HOLD_SHORT - 1);
   localparam logic [CNT_W-1:0] HOLD_L = CNT_W'(HOLD_LONG - 1);
   rsc_state_t       state_reg;
   rsc_state_t       state_next;
   logic [CNT_W-1:0] cnt_reg;
   logic             smr_reg;
   logic             cnt_done;
   logic             in_reset;
   assign cnt_done = cnt_reg ==
                     (i_xtal_option ? HOLD_L : HOLD_S);
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         RSC_RUN:
            if (sys_req | smr_req)
               state_next = sup_bad ? RSC_WAIT : RSC_HOLD;
         RSC_WAIT:
            if (~sup_bad)
               state_next = RSC_HOLD;
         RSC_HOLD:
            if (sup_bad)
               state_next = RSC_WAIT;
            else if (cnt_done)
               state_next = pin_low ? RSC_PIN : RSC_RUN;
         RSC_PIN:
            if (sup_bad)
               state_next = RSC_WAIT;
            else if (~pin_low)
               state_next = RSC_RUN;
         default:
            state_next = RSC_WAIT;
      endcase
   end
   assign in_reset = state_next != RSC_RUN;
   // The recovery kind is taken live on the entry edge, not from a stale flag.
   logic smr_cur;
   logic sys_rst;
   logic pin_drive;
   assign smr_cur   = (state_reg == RSC_RUN) ? ~sys_req : smr_reg;
   assign sys_rst   = in_reset & ~smr_cur;
   // The pin is let go once the delay ends, so that only an outside
   // driver can keep it low while waiting for release.
   assign pin_drive = (state_next == RSC_WAIT) | (state_next == RSC_HOLD);

   // ==========================================================
   // Cause flags.
   logic [7:0] cause_reg;
   logic [7:0] cause_set;
   logic       sys_start;
   assign sys_start = (state_reg == RSC_RUN) & sys_req;
   assign cause_set[CAUSE_POR]  = sys_start & (sup_bad | dbg_sys);
   assign cause_set[CAUSE_STOP] = (state_reg == RSC_RUN) & ~sys_req & smr_req;
   assign cause_set[CAUSE_WDT]  = (state_reg == RSC_RUN) & i_watchdog_timeout
                                  & (wdt_sys | smr_req);
   assign cause_set[CAUSE_EXT]  = sys_start & pin_req;
   assign cause_set[3:0]        = 4'h0;

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         state_reg <= RSC_WAIT;
         cnt_reg   <= '0;
         smr_reg   <= 1'b0;
         cause_reg <= 8'h80;
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg   <= (state_next == RSC_HOLD && state_reg == RSC_HOLD) ?
                      cnt_reg + CNT_W'(1) : '0;
         if (state_reg == RSC_RUN && in_reset)
            smr_reg <= ~sys_req;
         // Set wins over the read clear.
         if (sys_start)
            cause_reg <= cause_set;
         else
            cause_reg <= ({4'h0, cause_reg[3:0]} & {8{i_cause_read}}
                         | cause_reg & {8{~i_cause_read}}) | cause_set;
      end
   end

   // ==========================================================
   // Output registers.
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         o_cpu_reset            <= 1'b1;
         o_periph_reset         <= 1'b1;
         o_ctrl_reg_load        <= 1'b1;
         o_wdt_oscillator_control_register_reset    <= 1'b1;
         o_debugger_bit_clear   <= 1'b1;
         o_gpio_reset           <= 1'b1;
         o_sysclk_sel_ipo       <= 1'b1;
         o_shared_reset_pin_out <= 1'b0;
         o_shared_reset_pin_oe  <= 1'b1;
         o_brownout_enable      <= 1'b1;
         o_watchdog_irq         <= 1'b0;
         o_vector_addr          <= RESET_VECTOR_ADDR;
         o_reset_cause_status   <= 8'h80;
      end
      else
      begin
         o_cpu_reset            <= in_reset;
         o_periph_reset         <= sys_rst;
         o_ctrl_reg_load        <= sys_rst;
         o_wdt_oscillator_control_register_reset    <= in_reset;
         o_debugger_bit_clear   <= sys_rst;
         o_gpio_reset           <= sys_rst;
         o_sysclk_sel_ipo       <= in_reset;
         o_shared_reset_pin_out <= 1'b0;
         o_shared_reset_pin_oe  <= pin_drive;
         o_brownout_enable      <= bo_active;
         o_watchdog_irq         <= i_watchdog_timeout
                                   & ~i_watchdog_reset_select_option;
         o_vector_addr          <= RESET_VECTOR_ADDR;
         o_reset_cause_status   <= cause_reg;
      end
   end

   // ==========================================================
   // Checks.
   int unsigned hold_cnt;
   always_ff @(posedge i_clk)
   begin
      if (i_rst || state_reg != RSC_HOLD)
         hold_cnt <= 0;
      else
         hold_cnt <= hold_cnt + 1;
   end
   default clocking cb_chk @(posedge i_clk);
   endclocking
   default disable iff (i_rst);
   sequence s_hold_end;
      state_reg == RSC_HOLD && state_next != RSC_HOLD && !sup_bad;
   endsequence
   a_hold_short: assert property (
      (s_hold_end and !i_xtal_option) |-> hold_cnt == HOLD_SHORT - 1)
      else $error("Short hold length wrong.");
   a_hold_long: assert property (
      (s_hold_end and i_xtal_option) |-> hold_cnt == HOLD_LONG - 1)
      else $error("Long hold length wrong.");
   a_wait_supply: assert property (
      state_reg == RSC_WAIT && sup_bad |=> state_reg == RSC_WAIT)
      else $error("Left wait with supply low.");
   a_pin_stays: assert property (
      state_reg == RSC_PIN && pin_low && !sup_bad |=> o_cpu_reset)
      else $error("Released while pin low.");
   a_cpu_reset_out: assert property (
      state_reg != RSC_RUN |-> o_cpu_reset)
      else $error("CPU not held in reset.");
   a_pin_drive: assert property (
      o_cpu_reset && state_reg != RSC_PIN
      |-> o_shared_reset_pin_oe && !o_shared_reset_pin_out)
      else $error("Reset pin not driven low.");
   a_pin_release: assert property (
      state_reg == RSC_PIN |-> !o_shared_reset_pin_oe)
      else $error("Reset pin still driven after delay.");
   a_smr_keep_regs: assert property (
      state_reg == RSC_HOLD && smr_reg |=> !o_ctrl_reg_load)
      else $error("Recovery reloaded registers.");
   a_wdt_irq: assert property (
      i_watchdog_timeout && !i_watchdog_reset_select_option
      |=> o_watchdog_irq)
      else $error("Watchdog interrupt missing.");
   a_ext_flag: assert property (
      state_reg == RSC_RUN && pin_req
      |=> ##1 o_reset_cause_status[CAUSE_EXT])
      else $error("External flag not set.");
endmodule
`default_nettype wire

// ===== inc/rsc_pkg.sv
package rsc_pkg;
   // ==========================================================
   // Timing.
   localparam int unsigned CLK_HZ        = 10_000_000;
   localparam int unsigned HOLD_SHORT    = 66;
   localparam int unsigned HOLD_LONG     = 5000;
   localparam int unsigned PIN_MIN_CLKS  = 4;
   localparam int unsigned GLITCH_NS     = 12;
   localparam int unsigned CNT_W         = 13;
   localparam logic [15:0] RESET_VECTOR_ADDR = 16'h0002;
   // ==========================================================
   // Reset cause flag positions.
   localparam int unsigned CAUSE_POR  = 7;
   localparam int unsigned CAUSE_STOP = 6;
   localparam int unsigned CAUSE_WDT  = 5;
   localparam int unsigned CAUSE_EXT  = 4;
   localparam int unsigned GPIO_W     = 8;
   // ==========================================================
   // Controller states.
   typedef enum logic [1:0]
   {
      RSC_RUN  = 2'b00,
      RSC_WAIT = 2'b01,
      RSC_HOLD = 2'b10,
      RSC_PIN  = 2'b11
   } rsc_state_t;
endpackage

// ===== bench/rsc_ext_reset_src.sv
`timescale 1ns/1ps
`default_nettype none
module rsc_ext_reset_src
   import rsc_pkg::*;
(
   // Clock and reset.
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   // Command.
   input  wire logic        i_start,
   input  wire logic [15:0] i_len,
   // Pin drive.
   output logic             o_pull_low
);
   // =====
   // Pulls the shared reset pin low for a commanded number of clocks.
   logic [15:0] cnt_reg;
   always_ff @(posedge i_clk)
      if (i_rst)
         cnt_reg <= 16'h0000;
      else if (i_start)
         cnt_reg <= i_len;
      else if (cnt_reg != 16'h0000)
         cnt_reg <= cnt_reg - 16'h0001;
   assign o_pull_low = (cnt_reg != 16'h0000);
endmodule
`default_nettype wire

// ===== bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
   import rsc_pkg::*;
;
   // =====
   // Signals.
   logic        clk, rst, xtal, wsel, bao, stop, pen, sok, bo, wdt;
   logic        dbg, dpe, crd, go;
   logic [7:0]  gin, gen, cause;
   logic [15:0] len, vec;
   logic        pout, poe, cpu, per, crl, wdo, dbc, grs, internal_precision_osc, boe, irq;
   wire logic   pin, xlow;
   int          error_cnt = 0;
   int          comparisons = 0;
   // Open-drain wire with pull-up.
   assign pin = !((poe && !pout) || xlow);
   rsc_reset_ctrl uut (.i_clk(clk), .i_rst(rst), .i_xtal_option(xtal),
      .i_watchdog_reset_select_option(wsel),
      .i_brownout_always_on_option(bao), .i_stop_mode(stop),
      .i_pin_reset_enable(pen), .i_supply_ok(sok),
      .i_supply_brownout_reset(bo), .i_watchdog_timeout(wdt),
      .i_debugger_control_register_bit0(dbg), .i_debug_pin_error(dpe),
      .i_gpio_in(gin), .i_gpio_recovery_en(gen), .i_cause_read(crd),
      .i_shared_reset_pin(pin), .o_shared_reset_pin_out(pout),
      .o_shared_reset_pin_oe(poe), .o_cpu_reset(cpu),
      .o_periph_reset(per), .o_ctrl_reg_load(crl),
      .o_wdt_oscillator_control_register_reset(wdo), .o_debugger_bit_clear(dbc),
      .o_gpio_reset(grs), .o_sysclk_sel_ipo(internal_precision_osc),
      .o_brownout_enable(boe), .o_watchdog_irq(irq),
      .o_vector_addr(vec), .o_reset_cause_status(cause));
   rsc_ext_reset_src ext (.i_clk(clk), .i_rst(rst), .i_start(go),
      .i_len(len), .o_pull_low(xlow));
   // =====
   // Tasks.
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic chk(input string s, input logic [15:0] e, g);
      comparisons++;
      if (g !== e)
      begin
         $display("unexpected %s exp %h got %h", s, e, g);
         error_cnt++;
      end
   endtask
   task automatic chk_span(input string s, input int lo, hi, g);
      comparisons++;
      if (g < lo || g > hi)
      begin
         $display("unexpected %s exp %0d..%0d got %0d", s, lo, hi, g);
         error_cnt++;
      end
   endtask
   task automatic pull(input int n);
      len = n[15:0];
      go = 1'b1;
      tick(1);
      go = 1'b0;
   endtask
   task automatic pulse_wdt;
      wdt = 1'b1;
      tick(1);
      wdt = 1'b0;
   endtask
   task automatic run_reset(input int lo, hi, input logic [7:0] c,
                            input logic s);
      int n = 0;
      int w = 0;
      while (cpu !== 1'b1 && w < 40)
      begin
         w++;
         tick(1);
      end
      chk("cpu_reset", 1, cpu);
      chk("periph", s, per);
      chk("ctrl_load", s, crl);
      chk("gpio_reset", s, grs);
      chk("dbg_clear", s, dbc);
      chk("wdt_osc", 1, wdo);
      chk("ipo_sel", 1, internal_precision_osc);
      if (s)
         chk("pin_oe", 1, poe & !pout);
      stop = 1'b0;
      while (cpu === 1'b1 && n < 6000)
      begin
         n++;
         tick(1);
      end
      chk_span("hold", lo, hi, n);
      chk("cause", c, cause);
      chk("vector", 16'h0002, vec);
      chk("pin_rel", 0, poe);
      crd = 1'b1;
      tick(1);
      crd = 1'b0;
      tick(1);
      chk("cause_clr", 0, cause);
   endtask
   task automatic finish_test;
      $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // =====
   // Clock and watchdog.
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial
   begin
      #1_200_000;
      error_cnt++;
      finish_test();
   end
   // =====
   // Tests.
   initial
   begin
      {rst, sok, wsel, pen} = 4'hF;
      {xtal, bao, stop, bo, wdt, dbg, dpe, crd, go} = 9'h000;
      {gin, gen, len} = 32'h0000_0000;
      tick(4);
      chk("por_cause", 8'h80, cause);
      rst = 1'b0;
      run_reset(66, 74, 8'h80, 1);
      pulse_wdt();
      run_reset(66, 72, 8'h20, 1);
      xtal = 1'b1;
      pulse_wdt();
      run_reset(5000, 5006, 8'h20, 1);
      xtal = 1'b0;
      wsel = 1'b0;
      pulse_wdt();
      chk("irq", 1, irq);
      tick(1);
      chk("irq_end", 0, irq);
      pull(2);
      tick(20);
      chk("short_pin", 0, cpu);
      pen = 1'b0;
      pull(10);
      tick(20);
      chk("pin_off", 0, cpu);
      pen = 1'b1;
      pull(6);
      run_reset(64, 70, 8'h10, 1);
      pull(300);
      run_reset(290, 306, 8'h10, 1);
      dbg = 1'b1;
      tick(1);
      dbg = 1'b0;
      run_reset(66, 72, 8'h80, 1);
      {stop, gen} = 9'h101;
      gin[0] = 1'b1;
      run_reset(64, 72, 8'h40, 0);
      stop = 1'b1;
      wsel = 1'b1;
      pulse_wdt();
      run_reset(66, 72, 8'h60, 0);
      stop = 1'b1;
      pull(2);
      run_reset(64, 70, 8'h10, 1);
      stop = 1'b1;
      dpe = 1'b1;
      tick(5);
      dpe = 1'b0;
      run_reset(64, 72, 8'h80, 1);
      {sok, bo} = 2'b01;
      fork
         run_reset(108, 124, 8'h80, 1);
         begin
            tick(50);
            {sok, bo} = 2'b10;
         end
      join
      {stop, bao} = 2'b10;
      tick(2);
      chk("bo_stop_off", 0, boe);
      bao = 1'b1;
      tick(2);
      chk("bo_stop_on", 1, boe);
      finish_test();
   end
endmodule
`default_nettype wire
